/* File: design/swk_switch_wakeup_config.sv */
`timescale 1ns/10ps
// Overview of operation
// - Wake bit zero: changes on that input never end sleep.
// - Wake bit one: open or closed change on that input ends sleep.
// - Host may rewrite wake enables at any time; writes are accepted.
// - After reset every implemented wake enable bit is one.
// - All programmable and ground wake bits zero: polling timer stops in sleep.
// - Comparator-only programmable channel keeps comparator on in sleep, no polling current.
// - Comparator-only channel samples at sleep clock, wakes on level change.
// - Frame: address bits 31-25, write flag bit 24, data bits 23-0.
// - Reply: fault summary bit 23, interrupt flag bit 22, data bits 21-0.
// - Programmable wake register at 0x10, enables in low eight bits.
// - Ground-switch wake register at 0x11, enables in bits 13-0.
// - Comparator-only register at 0x12, low eight bits, reset to zero.
// - Programmable channel senses ground or battery switch; sleep behaviour follows.
module swk_switch_wakeup_config #(
    parameter int PROG_CH = swk_pkg::PROG_CHANNELS,
    parameter int GND_CH  = swk_pkg::GND_CHANNELS
) (
    input  wire logic              ref_clk,          // Device clock
    input  wire logic              rst,              // Synchronous reset, active high
    input  wire logic              spiCsN,           // Chip select, active low
    input  wire logic              spiSclk,          // Serial clock
    input  wire logic              spiMosi,          // Serial data in
    output logic                   spiMiso,          // Serial data out
    output logic                   spiMisoEnN,       // Low while driving spiMiso
    input  wire logic              faultSummary,     // Device fault summary
    input  wire logic              interruptFlag,    // Device interrupt flag
    input  wire logic              sleepMode,        // Device is in sleep mode
    input  wire logic              sleepTick,        // One-cycle sleep clock strobe
    input  wire logic [PROG_CH-1:0] progClosed,      // Polled programmable states
    input  wire logic [PROG_CH-1:0] progCompIn,      // Programmable comparator outputs
    input  wire logic [PROG_CH-1:0] progSenseBattery,// Channel senses battery switch
    input  wire logic [GND_CH-1:0]  gndClosed,       // Polled ground-switch states
    output logic                   wakeUp,           // Request: leave sleep mode, held while a polled change lasts
    output logic                   pollTimerEn,      // Polling timer runs
    output logic [PROG_CH-1:0]     progCompActive,   // Comparator kept on in sleep
    output logic [PROG_CH-1:0]     progPullUpEn,     // Polling current to ground switch
    output logic [PROG_CH-1:0]     progPullDownEn,   // Polling current to battery switch
    output logic [GND_CH-1:0]      gndPullUpEn,      // Ground-switch polling current
    output logic [PROG_CH-1:0]     wakeProg,         // Programmable wake enables
    output logic [GND_CH-1:0]      wakeGnd           // Ground-switch wake enables
);
    if (PROG_CH < 1 || PROG_CH > 8 || GND_CH < 1 || GND_CH > 14) begin : g_bad_param
        $error("Channel count out of range");
    end

    // SPI frame engine
    swk_pkg::swk_spi_state_t spiState_q, spiState_d;
    logic [5:0]  bitCnt_q, bitCnt_d;
    logic [31:0] rxShift_q, rxShift_d;
    logic [31:0] txShift_q, txShift_d;
    logic [6:0]  lastAddr_q, lastAddr_d;
    logic        lastRw_q, lastRw_d;
    logic        sclkPrev_q, sclkPrev_d;
    logic        frameDone;
    logic [21:0] readData;

    // Registers
    logic [PROG_CH-1:0] wakeProg_q, wakeProg_d;
    logic [GND_CH-1:0]  wakeGnd_q, wakeGnd_d;
    logic [PROG_CH-1:0] compProg_q, compProg_d;

    always_comb begin
        readData = '0;
        if (lastAddr_q == swk_pkg::ADDR_WAKE_PROG) begin
            readData[PROG_CH-1:0] = wakeProg_q;
        end else if (lastAddr_q == swk_pkg::ADDR_WAKE_GND) begin
            readData[GND_CH-1:0] = wakeGnd_q;
        end else if (lastAddr_q == swk_pkg::ADDR_COMP_PROG) begin
            readData[PROG_CH-1:0] = compProg_q;
        end
    end

    always_comb begin
        spiState_d = spiState_q;
        bitCnt_d   = bitCnt_q;
        rxShift_d  = rxShift_q;
        txShift_d  = txShift_q;
        lastAddr_d = lastAddr_q;
        lastRw_d   = lastRw_q;
        sclkPrev_d = spiSclk;
        frameDone  = 1'b0;
        case (spiState_q)
            swk_pkg::SPI_IDLE: begin
                if (!spiCsN) begin
                    spiState_d = swk_pkg::SPI_SHIFT;
                    bitCnt_d   = 6'h00;
                    // Reply answers the previous frame
                    txShift_d  = {lastAddr_q, lastRw_q, faultSummary, interruptFlag, readData};
                end
            end
            swk_pkg::SPI_SHIFT: begin
                if (spiCsN) begin
                    spiState_d = swk_pkg::SPI_IDLE;
                    if (bitCnt_q == 6'h20) begin
                        frameDone  = 1'b1;
                        lastAddr_d = rxShift_q[swk_pkg::ADDR_MSB:swk_pkg::ADDR_LSB];
                        lastRw_d   = rxShift_q[swk_pkg::RW_BIT];
                    end
                end else if (spiSclk && !sclkPrev_q) begin
                    rxShift_d = {rxShift_q[30:0], spiMosi};
                    if (bitCnt_q != 6'h3f)
                        bitCnt_d = bitCnt_q + 6'h01;
                end else if (!spiSclk && sclkPrev_q && bitCnt_q != 6'h00) begin
                    txShift_d = {txShift_q[30:0], 1'b0};
                end
            end
            default: begin
                spiState_d = swk_pkg::SPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            spiState_q <= swk_pkg::SPI_IDLE;
            bitCnt_q   <= 6'h00;
            rxShift_q  <= 32'h0000_0000;
            txShift_q  <= 32'h0000_0000;
            lastAddr_q <= 7'h00;
            lastRw_q   <= 1'b0;
            sclkPrev_q <= 1'b0;
        end else begin
            spiState_q <= spiState_d;
            bitCnt_q   <= bitCnt_d;
            rxShift_q  <= rxShift_d;
            txShift_q  <= txShift_d;
            lastAddr_q <= lastAddr_d;
            lastRw_q   <= lastRw_d;
            sclkPrev_q <= sclkPrev_d;
        end
    end

    assign spiMiso    = txShift_q[31];
    assign spiMisoEnN = (spiState_q != swk_pkg::SPI_SHIFT);

    // Register writes, accepted whatever the mode
    always_comb begin
        wakeProg_d = wakeProg_q;
        wakeGnd_d  = wakeGnd_q;
        compProg_d = compProg_q;
        if (frameDone && rxShift_q[swk_pkg::RW_BIT] == swk_pkg::RW_WRITE) begin
            if (rxShift_q[31:25] == swk_pkg::ADDR_WAKE_PROG) begin
                wakeProg_d = rxShift_q[PROG_CH-1:0];
            end else if (rxShift_q[31:25] == swk_pkg::ADDR_WAKE_GND) begin
                wakeGnd_d = rxShift_q[GND_CH-1:0];
            end else if (rxShift_q[31:25] == swk_pkg::ADDR_COMP_PROG) begin
                compProg_d = rxShift_q[PROG_CH-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wakeProg_q <= swk_pkg::WAKE_PROG_RESET[PROG_CH-1:0];
            wakeGnd_q  <= swk_pkg::WAKE_GND_RESET[GND_CH-1:0];
            compProg_q <= swk_pkg::COMP_PROG_RESET[PROG_CH-1:0];
        end else begin
            wakeProg_q <= wakeProg_d;
            wakeGnd_q  <= wakeGnd_d;
            compProg_q <= compProg_d;
        end
    end

    assign wakeProg = wakeProg_q;
    assign wakeGnd  = wakeGnd_q;

    // Wake detection
    logic               sleepPrev_q, sleepPrev_d;
    logic [PROG_CH-1:0] progRef_q, progRef_d;
    logic [GND_CH-1:0]  gndRef_q, gndRef_d;
    logic [PROG_CH-1:0] compSample_q, compSample_d;
    logic               wakeUp_q, wakeUp_d;
    logic               pollTimerEn_q, pollTimerEn_d;
    logic [PROG_CH-1:0] progHit;
    logic [GND_CH-1:0]  gndHit;
    logic               sleepEntry;

    assign sleepEntry = sleepMode && !sleepPrev_q;

    genvar p;
    generate
        for (p = 0; p < PROG_CH; p++) begin : g_prog
            // Comparator channels compare consecutive sleep-clock samples
            assign progHit[p] = wakeProg_q[p] && (compProg_q[p]
                ? (sleepTick && progCompIn[p] != compSample_q[p])
                : (progClosed[p] != progRef_q[p]));
            assign progCompActive[p] = sleepMode && compProg_q[p];
            // Pull-down for battery switches, pull-up for ground switches
            assign progPullDownEn[p] = !compProg_q[p] && progSenseBattery[p];
            assign progPullUpEn[p]   = !compProg_q[p] && !progSenseBattery[p];
        end
        for (p = 0; p < GND_CH; p++) begin : g_gnd
            assign gndHit[p] = wakeGnd_q[p] && (gndClosed[p] != gndRef_q[p]);
        end
    endgenerate

    assign gndPullUpEn = {GND_CH{1'b1}};

    always_comb begin
        sleepPrev_d   = sleepMode;
        progRef_d     = progRef_q;
        gndRef_d      = gndRef_q;
        compSample_d  = compSample_q;
        wakeUp_d      = 1'b0;
        // Timer runs in normal mode or while any channel may wake
        pollTimerEn_d = !sleepMode || (|wakeProg_q) || (|wakeGnd_q);
        if (!sleepMode || sleepEntry) begin
            progRef_d    = progClosed;
            gndRef_d     = gndClosed;
            compSample_d = progCompIn;
        end else begin
            if (sleepTick)
                compSample_d = progCompIn;
            wakeUp_d = (|progHit) || (|gndHit);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sleepPrev_q   <= 1'b0;
            progRef_q     <= '0;
            gndRef_q      <= '0;
            compSample_q  <= '0;
            wakeUp_q      <= 1'b0;
            pollTimerEn_q <= 1'b1;
        end else begin
            sleepPrev_q   <= sleepPrev_d;
            progRef_q     <= progRef_d;
            gndRef_q      <= gndRef_d;
            compSample_q  <= compSample_d;
            wakeUp_q      <= wakeUp_d;
            pollTimerEn_q <= pollTimerEn_d;
        end
    end

    assign wakeUp      = wakeUp_q;
    assign pollTimerEn = pollTimerEn_q;
endmodule

/* File: include/swk_pkg.sv */
package swk_pkg;
    // Frame layout
    localparam int        FRAME_BITS   = 32;
    localparam int        ADDR_MSB     = 31;
    localparam int        ADDR_LSB     = 25;
    localparam int        RW_BIT       = 24;
    localparam int        FAULT_BIT    = 23;
    localparam int        IRQ_FLAG_BIT = 22;
    localparam int        DATA_BITS    = 22;
    localparam logic      RW_WRITE     = 1'h1;

    // Register addresses
    localparam logic [6:0] ADDR_WAKE_PROG = 7'h10;
    localparam logic [6:0] ADDR_WAKE_GND  = 7'h11;
    localparam logic [6:0] ADDR_COMP_PROG = 7'h12;

    // Channel counts and reset values
    localparam int         PROG_CHANNELS   = 8;
    localparam int         GND_CHANNELS    = 14;
    localparam logic [7:0]  WAKE_PROG_RESET = 8'hff;
    localparam logic [13:0] WAKE_GND_RESET  = 14'h3fff;
    localparam logic [7:0]  COMP_PROG_RESET = 8'h00;

    typedef enum logic [1:0] {
        SPI_IDLE  = 2'b00,
        SPI_SHIFT = 2'b01
    } swk_spi_state_t;
endpackage

/* File: tb/swk_host_model.sv */
`timescale 1ns/10ps
module swk_host_model (
    input  wire logic ref_clk, // Clock
    output logic      csN,     // Select
    output logic      sclk,    // Idle low
    output logic      mosi,    // Data out
    input  wire logic miso     // Data in
);
    int half = 4;
    initial begin
        csN  = 1'h1;
        sclk = 1'h0;
        mosi = 1'h0;
    end
    // Mode 0, MSB first; released data line toggles
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        csN  <= 1'h0;
        mosi <= tx[31];
        repeat (half) @(posedge ref_clk);
        for (int i = 31; i >= 0; i--) begin
            rx[i] = miso;
            sclk <= 1'h1;
            repeat (half) @(posedge ref_clk);
            sclk <= 1'h0;
            mosi <= tx[(i + 31) % 32];
            repeat (half) @(posedge ref_clk);
        end
        csN  <= 1'h1;
        mosi <= ~mosi;
        repeat (half) @(posedge ref_clk);
    endtask
endmodule

/* File: tb/swk_monitor.sv */
`timescale 1ns/10ps
module swk_monitor #(
    parameter int PROG_CH = 8,
    parameter int GND_CH  = 14
) (
    input wire logic               ref_clk,        // Clock
    input wire logic               rst,            // Reset
    input wire logic               spiCsN,         // Select
    input wire logic               spiMisoEnN,     // Miso enable
    input wire logic               sleepMode,      // Sleep
    input wire logic [GND_CH-1:0]  gndClosed,      // Ground states
    input wire logic               wakeUp,         // Wake request
    input wire logic               pollTimerEn,    // Poll timer
    input wire logic [PROG_CH-1:0] progCompActive, // Comparator on
    input wire logic [PROG_CH-1:0] progPullUpEn,   // Pull-up
    input wire logic [PROG_CH-1:0] progPullDownEn, // Pull-down
    input wire logic [PROG_CH-1:0] wakeProg,       // Enables
    input wire logic [GND_CH-1:0]  wakeGnd         // Enables
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire allOff = (wakeProg == '0) && (wakeGnd == '0);
    sequence settledSleep;
        sleepMode[*3];
    endsequence
    sequence frameStart;
        spiCsN[*2] ##1 !spiCsN;
    endsequence
    AST_RST_WAKE: assert property ($fell(rst) |-> wakeProg == '1 && wakeGnd == '1)
        else $error("wake enables not set after reset");
    AST_POLL_OFF: assert property (sleepMode && allOff |=> !pollTimerEn)
        else $error("poll timer runs with no wake source");
    AST_POLL_ON: assert property (!allOff |=> pollTimerEn)
        else $error("poll timer stopped with a wake source");
    AST_NO_WAKE: assert property (sleepMode && allOff |=> !wakeUp)
        else $error("wake with all sources disabled");
    AST_GND_WAKE: assert property (settledSleep ##0 (!wakeUp && $stable(wakeGnd)
        && |((gndClosed ^ $past(gndClosed)) & wakeGnd)) |=> wakeUp)
        else $error("no wake on enabled ground change");
    AST_NO_CURR: assert property ((progCompActive & (progPullUpEn | progPullDownEn)) == '0)
        else $error("polling current on comparator channel");
    AST_COMP_IDLE: assert property (!sleepMode |-> progCompActive == '0)
        else $error("comparator kept on while awake");
    AST_MISO_ON: assert property (frameStart |=> !spiMisoEnN)
        else $error("miso not driven at frame start");
    AST_MISO_OFF: assert property ($rose(spiCsN) |=> spiMisoEnN)
        else $error("miso still driven after frame");
endmodule

bind swk_switch_wakeup_config swk_monitor #(.PROG_CH(PROG_CH), .GND_CH(GND_CH)) u_mon (
    .ref_clk(ref_clk), .rst(rst), .spiCsN(spiCsN), .spiMisoEnN(spiMisoEnN), .sleepMode(sleepMode),
    .gndClosed(gndClosed), .wakeUp(wakeUp), .pollTimerEn(pollTimerEn), .progCompActive(progCompActive),
    .progPullUpEn(progPullUpEn), .progPullDownEn(progPullDownEn), .wakeProg(wakeProg), .wakeGnd(wakeGnd));

/* File: tb/swk_switch_wakeup_config_tb.sv */
`timescale 1ns/10ps
module swk_switch_wakeup_config_tb;
    logic        ref_clk = 1'h0;
    logic        rst     = 1'h1;
    logic        spiCsN, spiSclk, spiMosi, spiMiso, spiMisoEnN, wakeUp, pollTimerEn, seen;
    logic        faultSummary, interruptFlag, sleepMode, sleepTick;
    logic [7:0]  progClosed, progCompIn, progSenseBattery, progCompActive, progPullUpEn, progPullDownEn, wakeProg;
    logic [13:0] gndClosed, gndPullUpEn, wakeGnd;
    logic [31:0] rx;
    int          bad_count, n_compared, cycles;
    always #2.5 ref_clk = ~ref_clk;
    swk_switch_wakeup_config DUT (.ref_clk(ref_clk), .rst(rst), .spiCsN(spiCsN), .spiSclk(spiSclk),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEnN(spiMisoEnN), .faultSummary(faultSummary),
        .interruptFlag(interruptFlag), .sleepMode(sleepMode), .sleepTick(sleepTick), .progClosed(progClosed),
        .progCompIn(progCompIn), .progSenseBattery(progSenseBattery), .gndClosed(gndClosed), .wakeUp(wakeUp),
        .pollTimerEn(pollTimerEn), .progCompActive(progCompActive), .progPullUpEn(progPullUpEn),
        .progPullDownEn(progPullDownEn), .gndPullUpEn(gndPullUpEn), .wakeProg(wakeProg), .wakeGnd(wakeGnd));
    swk_host_model host (.ref_clk(ref_clk), .csN(spiCsN), .sclk(spiSclk), .mosi(spiMosi), .miso(spiMiso));
    task automatic conclude;
        $display("checks %0d errors %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic access(input logic [6:0] addr, input logic wr, input logic [23:0] data);
        host.xfer({addr, wr, data}, rx);
    endtask
    task automatic waitWake(input int n);
        seen = 1'h0;
        repeat (n) begin
            @(posedge ref_clk);
            seen = seen | wakeUp;
        end
    endtask
    task automatic t_regs;
        logic [6:0]  addrs [5] = '{7'h10, 7'h11, 7'h12, 7'h7f, 7'h10};
        logic [21:0] vals  [4] = '{22'hff, 22'h3fff, 22'h0, 22'h0};
        check("wakeProg", 32'(wakeProg), 32'hff);
        check("wakeGnd", 32'(wakeGnd), 32'h3fff);
        check("gndPullUpEn", 32'(gndPullUpEn), 32'h3fff);
        faultSummary <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            access(addrs[i], 1'h0, 24'h0);
            if (i > 0)
                check("reply", rx, {addrs[i-1], 1'h0, 1'h1, 1'h0, vals[i-1]});
        end
    endtask
    task automatic t_write;
        access(7'h10, 1'h1, 24'hffff5a);
        check("wakeProg", 32'(wakeProg), 32'h5a);
        access(7'h11, 1'h1, 24'hffc003);
        check("wakeGnd", 32'(wakeGnd), 32'h3);
        access(7'h7f, 1'h1, 24'hffffff);
        access(7'h10, 1'h0, 24'h0);
        check("unmapped", rx, {7'h7f, 1'h1, 1'h1, 1'h0, 22'h0});
        check("regs kept", {wakeProg, wakeGnd}, {8'h5a, 14'h3});
    endtask
    task automatic t_reset;
        rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        check("wakeProg rst", 32'(wakeProg), 32'hff);
        check("wakeGnd rst", 32'(wakeGnd), 32'h3fff);
        check("pollTimerEn rst", 32'(pollTimerEn), 32'h1);
    endtask
    task automatic t_sleep;
        access(7'h10, 1'h1, 24'h0);
        access(7'h11, 1'h1, 24'h0);
        sleepMode <= 1'h1;
        repeat (4) @(posedge ref_clk);
        check("pollTimerEn", 32'(pollTimerEn), 32'h0);
        gndClosed  <= 14'h2aaa;
        progClosed <= 8'h0f;
        waitWake(10);
        check("wake off", 32'(seen), 32'h0);
        sleepMode <= 1'h0;
        access(7'h11, 1'h1, 24'h8);
        check("pollTimerEn", 32'(pollTimerEn), 32'h1);
        sleepMode <= 1'h1;
        repeat (4) @(posedge ref_clk);
        gndClosed <= gndClosed ^ 14'h1;
        waitWake(10);
        check("wake masked", 32'(seen), 32'h0);
        gndClosed <= gndClosed ^ 14'h8;
        waitWake(3);
        check("wake gnd", 32'(seen), 32'h1);
        sleepMode <= 1'h0;
    endtask
    task automatic t_comp;
        progSenseBattery <= 8'h02;
        access(7'h12, 1'h1, 24'h01);
        access(7'h10, 1'h1, 24'h01);
        access(7'h11, 1'h1, 24'h0);
        sleepMode <= 1'h1;
        repeat (4) @(posedge ref_clk);
        check("progCompActive", 32'(progCompActive), 32'h1);
        check("progPullDownEn", 32'(progPullDownEn), 32'h02);
        check("progPullUpEn", 32'(progPullUpEn), 32'hfc);
        progCompIn <= progCompIn ^ 8'h1;
        waitWake(6);
        check("wake no tick", 32'(seen), 32'h0);
        sleepTick <= 1'h1;
        @(posedge ref_clk);
        sleepTick <= 1'h0;
        waitWake(3);
        check("wake tick", 32'(seen), 32'h1);
        sleepMode <= 1'h0;
    endtask
    initial begin
        {faultSummary, interruptFlag, sleepMode, sleepTick} <= 4'h0;
        {progClosed, progCompIn, progSenseBattery} <= 24'h0;
        gndClosed <= 14'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        t_regs();
        host.half = 7;
        t_write();
        host.half = 4;
        t_reset();
        t_sleep();
        t_comp();
        conclude();
    end
endmodule
